// file: sim/cstr_far_card.sv
// the other card on the cable, as master of the lines the bench names
module cstr_far_card (
   input wire logic link_clk_in, // link clock
   input wire logic [5:0] drive_en_in, // lines it masters
   input wire logic [5:0] level_in, // levels it sends
   input wire logic [5:0] dut_line_in, // block's driven levels
   input wire logic [5:0] dut_oe_in, // block's enables
   output logic [5:0] wire_out // resolved cable levels
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] drv_en = 6'h00;
   logic [5:0] drv_lvl = 6'h00;
   logic [5:0] float_lvl = 6'h00;
   // one master per line: never fights the block; no pull, so idle lines wander
   always_ff @(posedge link_clk_in) begin
      drv_en <= drive_en_in & ~dut_oe_in;
      drv_lvl <= level_in;
      float_lvl <= ~wire_out;
   end
   // cable resolution from every party's enable
   always_comb begin
      wire_out = (dut_oe_in & dut_line_in) | (~dut_oe_in & drv_en & drv_lvl)
         | (~dut_oe_in & ~drv_en & float_lvl);
   end
endmodule : cstr_far_card

// file: sim/cstr_monitor.sv
module cstr_monitor (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // reset, active low
   input wire logic ce_in, // clock enable
   input wire logic link_clk_in, // link clock
   input wire logic [1:0] mode_timebase_in, // timebase mode
   input wire logic [1:0] mode_adc_convert_in, // convert mode
   input wire logic [1:0] mode_adc_trigger_in, // adc trigger mode
   input wire logic [1:0] mode_dac_trigger_in, // dac trigger mode
   input wire logic [1:0] mode_scan_begin_in, // scan begin mode
   input wire logic [1:0] timebase_src_in, // timebase source
   input wire logic [1:0] adc_trigger_src_in, // adc source
   input wire logic [1:0] dac_trigger_src_in, // dac source
   input wire logic osc_timebase_in, // oscillator
   input wire logic sw_adc_trigger_in, // sw adc trigger
   input wire logic analog_adc_trigger_in, // analog adc trigger
   input wire logic sw_dac_trigger_in, // sw dac trigger
   input wire logic analog_dac_trigger_in, // analog dac trigger
   input wire logic adc_convert_strobe_in, // own convert
   input wire logic scan_begin_pulse_in, // own scan begin
   input wire logic [5:0] link_line_out, // driven levels
   input wire logic [5:0] link_line_oe_out, // enables
   input wire logic timebase_out, // timebase in use
   input wire logic adc_trigger_out, // adc trigger in use
   input wire logic adc_convert_strobe_out, // convert in use
   input wire logic scan_begin_pulse_out, // scan begin in use
   input wire logic dac_trigger_out, // dac trigger in use
   input wire logic adc_trigger_echo_out, // adc echo
   input wire logic dac_trigger_echo_out // dac echo
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] run_cnt;
   // clean cycles since reset or stall, so $past never reaches into reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !ce_in) begin
         run_cnt <= 2'h0;
      end else if (run_cnt != 2'h3) begin
         run_cnt <= run_cnt + 2'h1;
      end
   end
   sequence s_settled;
      run_cnt == 2'h3;
   endsequence
   a_conv_own_src: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(mode_adc_convert_in, 2) != 2'h2 |-> adc_convert_strobe_out == $past(adc_convert_strobe_in))
      else $error("convert strobe not from own source");
   a_scan_own_src: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(mode_scan_begin_in, 2) != 2'h2 |-> scan_begin_pulse_out == $past(scan_begin_pulse_in))
      else $error("scan begin not from own source");
   a_tb_osc_src: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(timebase_src_in, 2) inside {2'h0, 2'h2} && $past(mode_timebase_in, 2) != 2'h2
      |-> timebase_out == $past(osc_timebase_in))
      else $error("timebase not from oscillator");
   a_adc_echo_src: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(adc_trigger_src_in, 2) < 2'h2 |-> adc_trigger_echo_out ==
      ($past(adc_trigger_src_in, 2) == 2'h0 ? $past(sw_adc_trigger_in) : $past(analog_adc_trigger_in)))
      else $error("adc echo not on chosen source");
   a_dac_echo_src: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(dac_trigger_src_in, 2) < 2'h2 |-> dac_trigger_echo_out ==
      ($past(dac_trigger_src_in, 2) == 2'h0 ? $past(sw_dac_trigger_in) : $past(analog_dac_trigger_in)))
      else $error("dac echo not on chosen source");
   a_adc_echo_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      adc_trigger_echo_out == adc_trigger_out)
      else $error("adc echo differs from trigger");
   a_dac_echo_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      dac_trigger_echo_out == dac_trigger_out)
      else $error("dac echo differs from trigger");
   // link source only counts while the line is slave, else the echo stays low
   a_adc_lnk_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(adc_trigger_src_in, 2) == 2'h3 && $past(mode_adc_trigger_in, 2) != 2'h2
      |-> !adc_trigger_echo_out)
      else $error("adc echo takes link while not slave");
   a_dac_lnk_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_settled ##0 $past(dac_trigger_src_in, 2) == 2'h3 && $past(mode_dac_trigger_in, 2) != 2'h2
      |-> !dac_trigger_echo_out)
      else $error("dac echo takes link while not slave");
   a_reset_quiet: assert property (@(posedge clk_in) !rst_n_in |=>
      {timebase_out, adc_trigger_out, adc_convert_strobe_out, scan_begin_pulse_out, dac_trigger_out} == 5'h00)
      else $error("outputs active in reset");
   a_idle_low: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
      (link_line_out & ~link_line_oe_out) == 6'h00)
      else $error("level on undriven line");
endmodule : cstr_monitor

// file: sim/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic link_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [1:0] mode [6] = '{default: 2'h0};
   logic [1:0] tb_src = 2'h0, adc_src = 2'h0, dac_src = 2'h0;
   logic [5:0] own = 6'h00, far_en = 6'h00, far_lvl = 6'h00;
   logic [4:0] aux = 5'h00;
   logic [5:0] link_line_in, link_line_out, link_line_oe_out;
   logic timebase_out, adc_trigger_out, adc_convert_strobe_out, scan_begin_pulse_out;
   logic dac_trigger_out, dac_update_strobe_out, adc_trigger_echo_out, dac_trigger_echo_out;
   logic [19:0] seen;
   logic [19:0] exp_q [$];
   logic [31:0] rnd = 32'h2654C49D;
   int n_fail = 0;
   int n_tests = 0;
   event look;
   card_sync_timing_router u_dut (.clk_in, .rst_n_in, .ce_in(1'b1), .link_clk_in,
      .mode_timebase_in(mode[0]), .mode_adc_trigger_in(mode[1]), .mode_adc_convert_in(mode[2]),
      .mode_scan_begin_in(mode[3]), .mode_dac_trigger_in(mode[4]), .mode_dac_update_in(mode[5]),
      .timebase_src_in(tb_src), .adc_trigger_src_in(adc_src), .dac_trigger_src_in(dac_src),
      .osc_timebase_in(own[0]), .ext_timebase_in(aux[0]), .sw_adc_trigger_in(own[1]),
      .analog_adc_trigger_in(aux[1]), .ext_adc_trigger_in(aux[2]), .sw_dac_trigger_in(own[4]),
      .analog_dac_trigger_in(aux[3]), .ext_dac_trigger_in(aux[4]), .adc_convert_strobe_in(own[2]),
      .scan_begin_pulse_in(own[3]), .dac_update_strobe_in(own[5]), .link_line_in, .link_line_out,
      .link_line_oe_out, .timebase_out, .adc_trigger_out, .adc_convert_strobe_out, .scan_begin_pulse_out,
      .dac_trigger_out, .dac_update_strobe_out, .adc_trigger_echo_out, .dac_trigger_echo_out);
   cstr_far_card u_far (.link_clk_in, .drive_en_in(far_en), .level_in(far_lvl),
      .dut_line_in(link_line_out), .dut_oe_in(link_line_oe_out), .wire_out(link_line_in));
   // snapshot: enables, levels, six signals in use (timebase lowest), echoes
   assign seen = {link_line_oe_out, link_line_out, dac_update_strobe_out, dac_trigger_out,
      scan_begin_pulse_out, adc_convert_strobe_out, adc_trigger_out, timebase_out,
      adc_trigger_echo_out, dac_trigger_echo_out};
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr_next
   task automatic chk(input logic [19:0] s, input logic [19:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // long settle covers the two-clock crossing both ways, with jitter
   task automatic settle_check(input logic [19:0] e);
      repeat (300) @(posedge clk_in);
      #1;
      exp_q.push_back(e);
      -> look;
   endtask : settle_check
   task automatic mode_case(input int k);
      logic [5:0] sl, ms, lv, fl, o;
      logic [1:0] mm;
      rnd = lfsr_next(rnd);
      lv = rnd[17:12];
      fl = rnd[23:18];
      for (int i = 0; i < 6; i++) begin
         mm = (k < 3) ? 2'(k) : rnd[2*i +: 2];
         mode[i] <= mm;
         ms[i] = (mm == 2'h1);
         sl[i] = (mm == 2'h2);
      end
      own <= lv;
      aux <= rnd[28:24];
      far_lvl <= fl;
      far_en <= sl;
      adc_src <= sl[1] ? 2'h2 : 2'h0;
      dac_src <= sl[4] ? 2'h3 : 2'h0;
      tb_src <= 2'h0;
      o = (sl & fl) | (~sl & lv);
      settle_check({ms, ms & lv, o, o[1], o[4]});
   endtask : mode_case
   task automatic src_case(input int k);
      logic [5:0] lv, o;
      logic [4:0] ax;
      rnd = lfsr_next(rnd);
      lv = rnd[5:0];
      ax = rnd[10:6];
      for (int i = 0; i < 6; i++) begin
         mode[i] <= 2'h0;
      end
      own <= lv;
      aux <= ax;
      far_en <= 6'h00;
      tb_src <= (k == 3) ? 2'h0 : 2'(k);
      adc_src <= 2'(k);
      dac_src <= 2'(k);
      o = lv;
      o[0] = (k == 1) ? ax[0] : lv[0];
      o[1] = (k == 0) ? lv[1] : (k == 1) ? ax[1] : (k == 2) ? ax[2] : 1'b0;
      o[4] = (k == 0) ? lv[4] : (k == 1) ? ax[3] : (k == 2) ? ax[4] : 1'b0;
      settle_check({12'h000, o, o[1], o[4]});
   endtask : src_case
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // system clock, 5 ns
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // link clock, 125 ns, odd offset so every rising edge lands 2.3 ns after a clk_in rising edge
   initial begin
      #17.3;
      forever #62.5 link_clk_in = ~link_clk_in;
   end
   // outputs watcher: oldest note against what the ports show
   initial begin
      forever begin
         @(look);
         chk(seen, exp_q.pop_front());
      end
   end
   // reset stays long enough for the link side to see it
   initial begin
      repeat (5) @(posedge clk_in);
      for (int i = 0; i < 6; i++) begin
         mode[i] <= 2'h1;
      end
      own <= 6'h3F;
      settle_check(20'h00000);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      $display("reset test done");
      for (int k = 0; k < 14; k++) begin
         @(posedge clk_in);
         mode_case(k);
      end
      $display("mode test done");
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_in);
         src_case(k);
      end
      $display("source test done");
      end_sim();
   end
   // about 6000 cycles expected, so twice that means a hang
   initial begin
      #60000;
      n_fail++;
      end_sim();
   end
endmodule : tb

bind card_sync_timing_router cstr_monitor u_mon (.clk_in, .rst_n_in, .ce_in, .link_clk_in,
   .mode_adc_trigger_in, .mode_dac_trigger_in,
   .mode_timebase_in, .mode_adc_convert_in, .mode_scan_begin_in, .timebase_src_in, .adc_trigger_src_in,
   .dac_trigger_src_in, .osc_timebase_in, .sw_adc_trigger_in, .analog_adc_trigger_in, .sw_dac_trigger_in,
   .analog_dac_trigger_in, .adc_convert_strobe_in, .scan_begin_pulse_in, .link_line_out, .link_line_oe_out,
   .timebase_out, .adc_trigger_out, .adc_convert_strobe_out, .scan_begin_pulse_out, .dac_trigger_out,
   .adc_trigger_echo_out, .dac_trigger_echo_out);

// file: src/card_sync_timing_router.sv
`include "cstr_params.svh"

// Behaviour
// [R1] each of six lines: master, slave, disabled
// [R2] other cards: one master per line
// [R3] other cards: one master, three slaves maximum
// [R4] line modes are fully independent
// [R5] timebase: drive out, or use received
// [R6] adc trigger: drive out, or received digital
// [R7] convert strobe: drive out, or use received
// [R8] scan begin: drive out, or use received
// [R9] dac trigger: drive out, or use received; code uses received only as digital or link source
// [R10] dac update: drive out, or use received
// [R11] line driven as master, sampled as slave
// [R12] reset selects internal sources, link idle
// [R13] master drives its own convert strobes out
// [R14] adc echo follows selected of four sources
// [R15] dac echo follows selected dac source
// [R16] timebase from internal, external or link
// [R17] scan begin synchronous, launches scan converts
// [R18] disabled line: not driven, not accepted
module card_sync_timing_router (
   input wire logic clk_in, // system clock, 200 MHz
   input wire logic rst_n_in, // synchronous reset, active low
   input wire logic ce_in, // clock enable, freezes state when low
   input wire logic link_clk_in, // link clock
   input wire logic [1:0] mode_timebase_in, // link mode, timebase
   input wire logic [1:0] mode_adc_trigger_in, // link mode, adc trigger
   input wire logic [1:0] mode_adc_convert_in, // link mode, convert strobe
   input wire logic [1:0] mode_scan_begin_in, // link mode, scan begin
   input wire logic [1:0] mode_dac_trigger_in, // link mode, dac trigger
   input wire logic [1:0] mode_dac_update_in, // link mode, dac update
   input wire logic [1:0] timebase_src_in, // timebase source choice
   input wire logic [1:0] adc_trigger_src_in, // adc trigger source choice
   input wire logic [1:0] dac_trigger_src_in, // dac trigger source choice
   input wire logic osc_timebase_in, // internal oscillator timebase
   input wire logic ext_timebase_in, // external timebase pin
   input wire logic sw_adc_trigger_in, // software adc trigger
   input wire logic analog_adc_trigger_in, // analog adc trigger
   input wire logic ext_adc_trigger_in, // external digital adc trigger pin
   input wire logic sw_dac_trigger_in, // software dac trigger
   input wire logic analog_dac_trigger_in, // analog dac trigger
   input wire logic ext_dac_trigger_in, // external digital dac trigger pin
   input wire logic adc_convert_strobe_in, // internal convert strobe
   input wire logic scan_begin_pulse_in, // internal scan begin pulse
   input wire logic dac_update_strobe_in, // internal dac update strobe
   input wire logic [5:0] link_line_in, // sync link lines, input side
   output logic [5:0] link_line_out, // sync link lines, output side
   output logic [5:0] link_line_oe_out, // sync link output enables
   output logic timebase_out, // timebase in use
   output logic adc_trigger_out, // adc trigger in use
   output logic adc_convert_strobe_out, // convert strobe in use
   output logic scan_begin_pulse_out, // scan begin in use
   output logic dac_trigger_out, // dac trigger in use
   output logic dac_update_strobe_out, // dac update in use
   output logic adc_trigger_echo_out, // copy of selected adc trigger
   output logic dac_trigger_echo_out // copy of selected dac trigger
);

   cstr_pkg::cstr_mode_t mode [`CSTR_NUM_LINES];
   cstr_pkg::cstr_tb_src_t tb_src;
   cstr_pkg::cstr_trig_src_t adc_src;
   cstr_pkg::cstr_trig_src_t dac_src;
   logic [2:0] pins_sync;
   logic [`CSTR_NUM_LINES-1:0] rx_link;
   logic [`CSTR_NUM_LINES-1:0] rx_sys;
   logic [`CSTR_NUM_LINES-1:0] internal_lvl;
   logic [`CSTR_NUM_LINES-1:0] tx_level;
   logic [`CSTR_NUM_LINES-1:0] tx_en;
   logic next_timebase;
   logic next_adc_dig;
   logic next_dac_dig;
   logic next_adc_trig;
   logic next_dac_trig;

   // slave takes received level, master and disabled keep internal
   function automatic logic cstr_pick(input cstr_pkg::cstr_mode_t m, input logic own, input logic rx);
      cstr_pick = (m == cstr_pkg::CSTR_SLAVE) ? rx : own; // R18
   endfunction : cstr_pick

   // received level only where the line is slave, else quiet
   function automatic logic cstr_accept(input cstr_pkg::cstr_mode_t m, input logic rx);
      cstr_accept = (m == cstr_pkg::CSTR_SLAVE) & rx; // R18
   endfunction : cstr_accept

   // trigger source select shared by adc and dac paths
   function automatic logic cstr_trig_mux(input cstr_pkg::cstr_trig_src_t s, input logic sw, input logic ana,
                                          input logic dig, input logic lnk);
      case (s)
         cstr_pkg::CSTR_TRIG_SW: cstr_trig_mux = sw;
         cstr_pkg::CSTR_TRIG_ANA: cstr_trig_mux = ana;
         cstr_pkg::CSTR_TRIG_DIG: cstr_trig_mux = dig;
         cstr_pkg::CSTR_TRIG_LNK: cstr_trig_mux = lnk;
         default: cstr_trig_mux = sw;
      endcase
   endfunction : cstr_trig_mux

   // mode registers, each line on its own field; reset falls back to disabled
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < `CSTR_NUM_LINES; i++) begin
            mode[i] <= cstr_pkg::CSTR_DISABLED; // R12
         end
      end else if (ce_in) begin
         mode[`CSTR_IDX_TIMEBASE] <= cstr_pkg::cstr_mode_t'(mode_timebase_in); // R1 R4
         mode[`CSTR_IDX_ADC_TRIG] <= cstr_pkg::cstr_mode_t'(mode_adc_trigger_in); // R1 R4
         mode[`CSTR_IDX_ADC_CONV] <= cstr_pkg::cstr_mode_t'(mode_adc_convert_in); // R1 R4
         mode[`CSTR_IDX_SCAN_BEGIN] <= cstr_pkg::cstr_mode_t'(mode_scan_begin_in); // R1 R4
         mode[`CSTR_IDX_DAC_TRIG] <= cstr_pkg::cstr_mode_t'(mode_dac_trigger_in); // R1 R4
         mode[`CSTR_IDX_DAC_UPDATE] <= cstr_pkg::cstr_mode_t'(mode_dac_update_in); // R1 R4
      end
   end

   // source choices; reset picks internal timebase and software triggers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tb_src <= cstr_pkg::CSTR_TB_INT; // R12
         adc_src <= cstr_pkg::CSTR_TRIG_SW; // R12
         dac_src <= cstr_pkg::CSTR_TRIG_SW; // R12
      end else if (ce_in) begin
         tb_src <= cstr_pkg::cstr_tb_src_t'(timebase_src_in);
         adc_src <= cstr_pkg::cstr_trig_src_t'(adc_trigger_src_in);
         dac_src <= cstr_pkg::cstr_trig_src_t'(dac_trigger_src_in);
      end
   end

   // external timebase and digital trigger pins are asynchronous; oscillator shares this clock
   cstr_sync2 #(.WIDTH(3)) u_pin_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .d_in({ext_dac_trigger_in, ext_adc_trigger_in, ext_timebase_in}),
      .q_out(pins_sync)
   );

   // link lines: sampled on the link clock, then crossed into this domain
   cstr_link_port u_link (
      .link_clk_in(link_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .tx_level_in(tx_level),
      .tx_en_in(tx_en),
      .line_in(link_line_in),
      .line_out(link_line_out),
      .line_oe_out(link_line_oe_out),
      .rx_level_out(rx_link)
   );

   cstr_sync2 #(.WIDTH(`CSTR_NUM_LINES)) u_rx_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .d_in(rx_link),
      .q_out(rx_sys)
   );

   // timebase choice; slave mode overrides and link source needs slave mode
   always_comb begin
      case (tb_src)
         cstr_pkg::CSTR_TB_INT: next_timebase = osc_timebase_in; // R16
         cstr_pkg::CSTR_TB_EXT: next_timebase = pins_sync[0]; // R16
         cstr_pkg::CSTR_TB_LNK: next_timebase = cstr_pick(mode[`CSTR_IDX_TIMEBASE], osc_timebase_in,
                                                          rx_sys[`CSTR_IDX_TIMEBASE]); // R16 R18
         default: next_timebase = osc_timebase_in;
      endcase
      if (mode[`CSTR_IDX_TIMEBASE] == cstr_pkg::CSTR_SLAVE) begin
         next_timebase = rx_sys[`CSTR_IDX_TIMEBASE]; // R5
      end
   end

   // as slave the received trigger stands in for the digital trigger pin
   always_comb begin
      next_adc_dig = cstr_pick(mode[`CSTR_IDX_ADC_TRIG], pins_sync[1], rx_sys[`CSTR_IDX_ADC_TRIG]); // R6
      next_dac_dig = cstr_pick(mode[`CSTR_IDX_DAC_TRIG], pins_sync[2], rx_sys[`CSTR_IDX_DAC_TRIG]); // R9
      next_adc_trig = cstr_trig_mux(adc_src, sw_adc_trigger_in, analog_adc_trigger_in, next_adc_dig,
                                    cstr_accept(mode[`CSTR_IDX_ADC_TRIG], rx_sys[`CSTR_IDX_ADC_TRIG])); // R14
      next_dac_trig = cstr_trig_mux(dac_src, sw_dac_trigger_in, analog_dac_trigger_in, next_dac_dig,
                                    cstr_accept(mode[`CSTR_IDX_DAC_TRIG], rx_sys[`CSTR_IDX_DAC_TRIG])); // R15
   end

   // own levels offered to the link
   always_comb begin
      internal_lvl[`CSTR_IDX_TIMEBASE] = next_timebase; // R5
      internal_lvl[`CSTR_IDX_ADC_TRIG] = next_adc_trig; // R6
      internal_lvl[`CSTR_IDX_ADC_CONV] = adc_convert_strobe_in; // R7 R13
      internal_lvl[`CSTR_IDX_SCAN_BEGIN] = scan_begin_pulse_in; // R8
      internal_lvl[`CSTR_IDX_DAC_TRIG] = next_dac_trig; // R9
      internal_lvl[`CSTR_IDX_DAC_UPDATE] = dac_update_strobe_in; // R10
   end

   // drive request per line; only a master line enables its driver
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_level <= `CSTR_RST_LINES; // R12
         tx_en <= `CSTR_RST_LINES; // R12
      end else if (ce_in) begin
         for (int i = 0; i < `CSTR_NUM_LINES; i++) begin
            tx_en[i] <= (mode[i] == cstr_pkg::CSTR_MASTER); // R11 R18
            tx_level[i] <= internal_lvl[i]; // R13
         end
      end
   end

   // signals in use; a slave's converts follow the master's strobe edges
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         timebase_out <= 1'b0;
         adc_trigger_out <= 1'b0;
         adc_convert_strobe_out <= 1'b0;
         scan_begin_pulse_out <= 1'b0;
         dac_trigger_out <= 1'b0;
         dac_update_strobe_out <= 1'b0;
      end else if (ce_in) begin
         timebase_out <= next_timebase; // R5 R16
         adc_trigger_out <= next_adc_trig; // R6
         adc_convert_strobe_out <= cstr_pick(mode[`CSTR_IDX_ADC_CONV], adc_convert_strobe_in,
                                             rx_sys[`CSTR_IDX_ADC_CONV]); // R7
         // kept a level on this clock, so downstream scan logic stays synchronous
         scan_begin_pulse_out <= cstr_pick(mode[`CSTR_IDX_SCAN_BEGIN], scan_begin_pulse_in,
                                           rx_sys[`CSTR_IDX_SCAN_BEGIN]); // R8 R17
         dac_trigger_out <= next_dac_trig; // R9
         dac_update_strobe_out <= cstr_pick(mode[`CSTR_IDX_DAC_UPDATE], dac_update_strobe_in,
                                            rx_sys[`CSTR_IDX_DAC_UPDATE]); // R10
      end
   end

   // trigger echoes registered in step with the triggers themselves
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         adc_trigger_echo_out <= 1'b0;
         dac_trigger_echo_out <= 1'b0;
      end else if (ce_in) begin
         adc_trigger_echo_out <= next_adc_trig; // R14
         dac_trigger_echo_out <= next_dac_trig; // R15
      end
   end

endmodule : card_sync_timing_router

// file: src/cstr_link_port.sv
`include "cstr_params.svh"

// link-side end of the six sync lines, clocked by the link clock
module cstr_link_port (
   input wire logic link_clk_in, // link clock
   input wire logic rst_n_in, // system reset, crossed in here
   input wire logic ce_in, // system clock enable, crossed in here
   input wire logic [`CSTR_NUM_LINES-1:0] tx_level_in, // levels to drive
   input wire logic [`CSTR_NUM_LINES-1:0] tx_en_in, // lines this card masters
   input wire logic [`CSTR_NUM_LINES-1:0] line_in, // line levels at pins
   output logic [`CSTR_NUM_LINES-1:0] line_out, // driven levels
   output logic [`CSTR_NUM_LINES-1:0] line_oe_out, // output enables
   output logic [`CSTR_NUM_LINES-1:0] rx_level_out // sampled line levels
);

   logic rst_meta;
   logic link_rst_n;
   logic ce_link;
   logic [2*`CSTR_NUM_LINES-1:0] tx_sync;

   // reset crossing: no reset of its own, first flop read only by second
   always_ff @(posedge link_clk_in) begin
      rst_meta <= rst_n_in;
      link_rst_n <= rst_meta;
   end

   cstr_sync2 #(.WIDTH(1)) u_ce_sync (
      .clk_in(link_clk_in),
      .rst_n_in(link_rst_n),
      .ce_in(1'b1),
      .d_in(ce_in),
      .q_out(ce_link)
   );

   // drive data and enables cross together as levels
   cstr_sync2 #(.WIDTH(2*`CSTR_NUM_LINES)) u_tx_sync (
      .clk_in(link_clk_in),
      .rst_n_in(link_rst_n),
      .ce_in(ce_link),
      .d_in({tx_en_in, tx_level_in}),
      .q_out(tx_sync)
   );

   // pins come from other cards: two flops before use
   cstr_sync2 #(.WIDTH(`CSTR_NUM_LINES)) u_rx_sync (
      .clk_in(link_clk_in),
      .rst_n_in(link_rst_n),
      .ce_in(ce_link),
      .d_in(line_in),
      .q_out(rx_level_out)
   );

   // a line is driven only where this card is master
   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         line_out <= `CSTR_RST_LINES; // R12
         line_oe_out <= `CSTR_RST_LINES; // R12
      end else if (ce_link) begin
         line_oe_out <= tx_sync[2*`CSTR_NUM_LINES-1:`CSTR_NUM_LINES]; // R11
         line_out <= tx_sync[`CSTR_NUM_LINES-1:0] & tx_sync[2*`CSTR_NUM_LINES-1:`CSTR_NUM_LINES]; // R11
      end
   end

endmodule : cstr_link_port

// file: src/cstr_params.svh
`ifndef CSTR_PARAMS_SVH
`define CSTR_PARAMS_SVH

// number of timing lines on the card sync link
`define CSTR_NUM_LINES 6

// bit index of each timing line in the link vectors
`define CSTR_IDX_TIMEBASE 0
`define CSTR_IDX_ADC_TRIG 1
`define CSTR_IDX_ADC_CONV 2
`define CSTR_IDX_SCAN_BEGIN 3
`define CSTR_IDX_DAC_TRIG 4
`define CSTR_IDX_DAC_UPDATE 5

// per-line link mode codes
`define CSTR_MODE_DISABLED 2'h0
`define CSTR_MODE_MASTER 2'h1
`define CSTR_MODE_SLAVE 2'h2

// timebase source codes
`define CSTR_TB_INTERNAL 2'h0
`define CSTR_TB_EXTERNAL 2'h1
`define CSTR_TB_LINK 2'h2

// trigger source codes
`define CSTR_TRIG_SOFTWARE 2'h0
`define CSTR_TRIG_ANALOG 2'h1
`define CSTR_TRIG_DIGITAL 2'h2
`define CSTR_TRIG_LINK 2'h3

// reset values
`define CSTR_RST_MODES 12'h000
`define CSTR_RST_LINES 6'h00

`endif

// file: src/cstr_pkg.sv
`include "cstr_params.svh"

package cstr_pkg;

   // link function of one timing line
   typedef enum logic [1:0] {
      CSTR_DISABLED = `CSTR_MODE_DISABLED,
      CSTR_MASTER = `CSTR_MODE_MASTER,
      CSTR_SLAVE = `CSTR_MODE_SLAVE
   } cstr_mode_t;

   // timebase source choice
   typedef enum logic [1:0] {
      CSTR_TB_INT = `CSTR_TB_INTERNAL,
      CSTR_TB_EXT = `CSTR_TB_EXTERNAL,
      CSTR_TB_LNK = `CSTR_TB_LINK
   } cstr_tb_src_t;

   // trigger source choice
   typedef enum logic [1:0] {
      CSTR_TRIG_SW = `CSTR_TRIG_SOFTWARE,
      CSTR_TRIG_ANA = `CSTR_TRIG_ANALOG,
      CSTR_TRIG_DIG = `CSTR_TRIG_DIGITAL,
      CSTR_TRIG_LNK = `CSTR_TRIG_LINK
   } cstr_trig_src_t;

endpackage : cstr_pkg

// file: src/cstr_sync2.sv
// two-stage level synchroniser with clock enable and synchronous reset
module cstr_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in, // destination clock
   input wire logic rst_n_in, // synchronous reset, active low
   input wire logic ce_in, // clock enable
   input wire logic [WIDTH-1:0] d_in, // level from another domain
   output logic [WIDTH-1:0] q_out // synchronised level
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta <= '0;
         q_out <= '0;
      end else if (ce_in) begin
         meta <= d_in;
         q_out <= meta;
      end
   end

endmodule : cstr_sync2
